// ---- hdl/clsc_pkg.sv ----
// Constants and types shared by the closed-loop speed curve block
package clsc_pkg;

  // ********************************************************
  // Widths
  // ********************************************************
  localparam int ADDR_W  = 5;
  localparam int CMD_W   = 9;
  localparam int DUTY_W  = 10;
  localparam int SPEED_W = 20;
  localparam int SLOPE_W = 14;
  localparam int LSPD_W  = 12;

  // ********************************************************
  // Register offsets and reset values
  // ********************************************************
  localparam logic [ADDR_W-1:0] OFS_HALT_DUTY_CTRL   = 5'h02;
  localparam logic [ADDR_W-1:0] OFS_LAUNCH_DUTY      = 5'h03;
  localparam logic [ADDR_W-1:0] OFS_KNEE_DUTY        = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_TOP_DUTY         = 5'h05;
  localparam logic [ADDR_W-1:0] OFS_LAUNCH_SPEED_HI  = 5'h06;
  localparam logic [ADDR_W-1:0] OFS_LAUNCH_SPEED_LO  = 5'h07;
  localparam logic [ADDR_W-1:0] OFS_SLOPE_FIRST_HI   = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_SLOPE_FIRST_LO   = 5'h09;
  localparam logic [ADDR_W-1:0] OFS_SLOPE_SECOND_HI  = 5'h0A;
  localparam logic [ADDR_W-1:0] OFS_SLOPE_SECOND_LO  = 5'h0B;
  localparam logic [ADDR_W-1:0] OFS_DECEL_CAP_CTRL   = 5'h12;
  localparam logic [7:0]        RST_REG              = 8'h00;

  // ********************************************************
  // Field positions
  // ********************************************************
  localparam int KEEP_SPINNING_LOW_BIT  = 7;
  localparam int FULL_DUTY_BYPASS_BIT   = 1;
  localparam int ZERO_CMD_FULL_SPD_BIT  = 0;
  localparam int LOOP_SELECT_BIT        = 0;
  localparam int DECEL_CAP_LSB          = 5;

  // ********************************************************
  // Curve arithmetic
  // ********************************************************
  localparam logic [DUTY_W-1:0] TOP_DUTY_BASE = 10'h101;
  localparam logic [DUTY_W-1:0] FULL_DUTY     = 10'h200;
  localparam int                SLOPE_SHIFT   = 6;

  // Decrease cap steps in rpm
  localparam logic [SPEED_W-1:0] CAP_STEP_1 = 20'h00200;
  localparam logic [SPEED_W-1:0] CAP_STEP_2 = 20'h00898;
  localparam logic [SPEED_W-1:0] CAP_STEP_3 = 20'h00ED8;
  localparam logic [SPEED_W-1:0] CAP_STEP_4 = 20'h01518;
  localparam logic [SPEED_W-1:0] CAP_STEP_5 = 20'h01B58;
  localparam logic [SPEED_W-1:0] CAP_STEP_6 = 20'h02198;
  localparam logic [SPEED_W-1:0] CAP_STEP_7 = 20'h02800;

  // ********************************************************
  // Timing
  // ********************************************************
  localparam int CLK_FREQ_MHZ        = 50;
  localparam int DECEL_PERIOD_US     = 1000;
  localparam int DECEL_PERIOD_CYCLES = DECEL_PERIOD_US * CLK_FREQ_MHZ;

  typedef enum logic [1:0] {
    ZONE_OPEN,
    ZONE_LOW,
    ZONE_CURVE,
    ZONE_BYPASS
  } clsc_zone_e;

endpackage

// ---- hdl/clsc_curve_calc.sv ----
// Piecewise-linear speed curve evaluated at one duty point
`timescale 1ns/1ps
module clsc_curve_calc (
  // Duty point and curve settings
  input  wire logic [9:0]  duty,
  input  wire logic [9:0]  launchDuty,
  input  wire logic [9:0]  kneeDuty,
  input  wire logic [11:0] launchSpeed,
  input  wire logic [13:0] slopeFirst,
  input  wire logic [13:0] slopeSecond,
  // Result in rpm
  output logic      [19:0] speed
);

  logic        kneeOn;
  logic [9:0]  firstEnd;
  logic [9:0]  firstDelta;
  logic [9:0]  secondDelta;
  logic [23:0] firstProd;
  logic [23:0] secondProd;

  always_comb begin
    kneeOn = (kneeDuty != 10'h000);
    firstEnd = (kneeOn && (duty > kneeDuty)) ? kneeDuty : duty;
    // Knee below launch is illegal; clamp keeps the sum sane
    firstDelta = (firstEnd > launchDuty) ? (firstEnd - launchDuty) : 10'h000;
    secondDelta = (kneeOn && (duty > kneeDuty) && (kneeDuty >= launchDuty)) ?
                  (duty - kneeDuty) : 10'h000;
    firstProd  = 24'(slopeFirst) * 24'(firstDelta);
    secondProd = 24'(slopeSecond) * 24'(secondDelta);
    speed = 20'(launchSpeed)
          + 20'(firstProd >> clsc_pkg::SLOPE_SHIFT)
          + 20'(secondProd >> clsc_pkg::SLOPE_SHIFT);
  end

endmodule

// ---- hdl/clsc_speed_map.sv ----
// Closed-loop speed command mapper with settings registers and decrease cap
`timescale 1ns/1ps
module clsc_speed_map #(
  parameter int unsigned DECEL_PERIOD_CYCLES = clsc_pkg::DECEL_PERIOD_CYCLES
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // Settings register port
  input  wire logic [4:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  output logic      [7:0]  regRdData,
  // Speed command, 9-bit duty in 1/512 steps
  input  wire logic [8:0]  speedCommand,
  // Results
  output logic      [19:0] targetSpeed,
  output logic             bypassActive,
  output logic      [9:0]  bypassDuty,
  output logic             loopClosed,
  output logic      [1:0]  curveZone
);

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic [7:0]           haltDutyCtrl;
    logic [7:0]           launchDutyReg;
    logic [7:0]           kneeDutyReg;
    logic [7:0]           topDutyReg;
    logic [7:0]           launchSpeedHigh;
    logic [7:0]           launchSpeedLow;
    logic [7:0]           slopeFirstHigh;
    logic [7:0]           slopeFirstLowFlags;
    logic [7:0]           slopeSecondHigh;
    logic [7:0]           slopeSecondLow;
    logic [7:0]           decelCapCtrl;
    logic [7:0]           rdData;
    logic [8:0]           lastCmd;
    logic                 dirDown;
    logic [31:0]          tickCnt;
    logic [19:0]          target;
    logic                 bypass;
    logic [9:0]           bypassDuty;
    logic                 loopClosed;
    clsc_pkg::clsc_zone_e zone;
  } clsc_state_s;

  localparam clsc_state_s STATE_RST = '{
    haltDutyCtrl:       clsc_pkg::RST_REG,
    launchDutyReg:      clsc_pkg::RST_REG,
    kneeDutyReg:        clsc_pkg::RST_REG,
    topDutyReg:         clsc_pkg::RST_REG,
    launchSpeedHigh:    clsc_pkg::RST_REG,
    launchSpeedLow:     clsc_pkg::RST_REG,
    slopeFirstHigh:     clsc_pkg::RST_REG,
    slopeFirstLowFlags: clsc_pkg::RST_REG,
    slopeSecondHigh:    clsc_pkg::RST_REG,
    slopeSecondLow:     clsc_pkg::RST_REG,
    decelCapCtrl:       clsc_pkg::RST_REG,
    rdData:             8'h00,
    lastCmd:            9'h000,
    dirDown:            1'b0,
    tickCnt:            32'h0000_0000,
    target:             20'h00000,
    bypass:             1'b0,
    bypassDuty:         10'h000,
    loopClosed:         1'b1,
    zone:               clsc_pkg::ZONE_LOW
  };

  localparam logic [31:0] TICK_LAST = 32'(DECEL_PERIOD_CYCLES - 1);

  clsc_state_s s;
  clsc_state_s next_s;

  // ********************************************************
  // Functions
  // ********************************************************
  // cap code to rpm step
  function automatic logic [19:0] decel_cap(input logic [2:0] code);
    logic [19:0] v;
    v = 20'h00000;
    case (code)
      3'h1:    v = clsc_pkg::CAP_STEP_1;
      3'h2:    v = clsc_pkg::CAP_STEP_2;
      3'h3:    v = clsc_pkg::CAP_STEP_3;
      3'h4:    v = clsc_pkg::CAP_STEP_4;
      3'h5:    v = clsc_pkg::CAP_STEP_5;
      3'h6:    v = clsc_pkg::CAP_STEP_6;
      3'h7:    v = clsc_pkg::CAP_STEP_7;
      default: v = 20'h00000;
    endcase
    return v;
  endfunction

  function automatic logic [7:0] read_mux(input clsc_state_s st, input logic [4:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      clsc_pkg::OFS_HALT_DUTY_CTRL:  v = st.haltDutyCtrl;
      clsc_pkg::OFS_LAUNCH_DUTY:     v = st.launchDutyReg;
      clsc_pkg::OFS_KNEE_DUTY:       v = st.kneeDutyReg;
      clsc_pkg::OFS_TOP_DUTY:        v = st.topDutyReg;
      clsc_pkg::OFS_LAUNCH_SPEED_HI: v = st.launchSpeedHigh;
      clsc_pkg::OFS_LAUNCH_SPEED_LO: v = st.launchSpeedLow;
      clsc_pkg::OFS_SLOPE_FIRST_HI:  v = st.slopeFirstHigh;
      clsc_pkg::OFS_SLOPE_FIRST_LO:  v = st.slopeFirstLowFlags;
      clsc_pkg::OFS_SLOPE_SECOND_HI: v = st.slopeSecondHigh;
      clsc_pkg::OFS_SLOPE_SECOND_LO: v = st.slopeSecondLow;
      clsc_pkg::OFS_DECEL_CAP_CTRL:  v = st.decelCapCtrl;
      default:                       v = 8'h00;
    endcase
    return v;
  endfunction

  // ********************************************************
  // Setting decode
  // ********************************************************
  logic [9:0]  cmdDuty;
  logic [9:0]  launchDuty;
  logic [9:0]  haltDuty;
  logic [9:0]  kneeDuty;
  logic [9:0]  topDuty;
  logic [9:0]  curveDuty;
  logic [11:0] launchSpeed;
  logic [13:0] slopeFirst;
  logic [13:0] slopeSecond;
  logic        keepSpinningLow;
  logic        fullDutyBypass;
  logic        zeroCmdFullSpeed;
  logic        loopSelect;
  logic [19:0] curveSpeed;
  logic [19:0] maxSpeed;

  always_comb begin
    cmdDuty          = {1'b0, speedCommand};
    launchDuty       = {2'b00, s.launchDutyReg};
    haltDuty         = {2'b00, s.haltDutyCtrl[6:0], 1'b0};
    kneeDuty         = {1'b0, s.kneeDutyReg, 1'b0};
    topDuty          = {2'b00, s.topDutyReg} + clsc_pkg::TOP_DUTY_BASE;
    launchSpeed      = {s.launchSpeedHigh, s.launchSpeedLow[7:4]};
    slopeFirst       = {s.slopeFirstHigh, s.slopeFirstLowFlags[7:2]};
    slopeSecond      = {s.slopeSecondHigh, s.slopeSecondLow[7:2]};
    keepSpinningLow  = s.haltDutyCtrl[clsc_pkg::KEEP_SPINNING_LOW_BIT];
    fullDutyBypass   = s.slopeFirstLowFlags[clsc_pkg::FULL_DUTY_BYPASS_BIT];
    zeroCmdFullSpeed = s.slopeFirstLowFlags[clsc_pkg::ZERO_CMD_FULL_SPD_BIT];
    loopSelect       = s.slopeSecondLow[clsc_pkg::LOOP_SELECT_BIT];
    curveDuty        = (cmdDuty > topDuty) ? topDuty : cmdDuty;
  end

  // ********************************************************
  // Curve evaluation
  // ********************************************************
  clsc_curve_calc u_curve_now (
    .duty        (curveDuty),
    .launchDuty  (launchDuty),
    .kneeDuty    (kneeDuty),
    .launchSpeed (launchSpeed),
    .slopeFirst  (slopeFirst),
    .slopeSecond (slopeSecond),
    .speed       (curveSpeed)
  );

  // Maximum speed is the curve value at top duty
  clsc_curve_calc u_curve_top (
    .duty        (topDuty),
    .launchDuty  (launchDuty),
    .kneeDuty    (kneeDuty),
    .launchSpeed (launchSpeed),
    .slopeFirst  (slopeFirst),
    .slopeSecond (slopeSecond),
    .speed       (maxSpeed)
  );

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    logic        isZero;
    logic        inHalt;
    logic        dirNow;
    logic        lowFull;
    logic        tick;
    logic [19:0] rawSpeed;
    logic [19:0] capStep;
    logic [19:0] floorSpeed;
    isZero     = (cmdDuty == 10'h000);
    inHalt     = (cmdDuty <= haltDuty);
    dirNow     = s.dirDown;
    lowFull    = 1'b0;
    tick       = (s.tickCnt >= TICK_LAST);
    rawSpeed   = 20'h00000;
    capStep    = decel_cap(s.decelCapCtrl[7:5]);
    floorSpeed = 20'h00000;
    next_s     = s;

    // Register writes; unmapped offsets are ignored
    if (regWrEn) begin
      case (regAddr)
        clsc_pkg::OFS_HALT_DUTY_CTRL:  next_s.haltDutyCtrl       = regWrData;
        clsc_pkg::OFS_LAUNCH_DUTY:     next_s.launchDutyReg      = regWrData;
        clsc_pkg::OFS_KNEE_DUTY:       next_s.kneeDutyReg        = regWrData;
        clsc_pkg::OFS_TOP_DUTY:        next_s.topDutyReg         = regWrData;
        clsc_pkg::OFS_LAUNCH_SPEED_HI: next_s.launchSpeedHigh    = regWrData;
        clsc_pkg::OFS_LAUNCH_SPEED_LO: next_s.launchSpeedLow     = regWrData;
        clsc_pkg::OFS_SLOPE_FIRST_HI:  next_s.slopeFirstHigh     = regWrData;
        clsc_pkg::OFS_SLOPE_FIRST_LO:  next_s.slopeFirstLowFlags = regWrData;
        clsc_pkg::OFS_SLOPE_SECOND_HI: next_s.slopeSecondHigh    = regWrData;
        clsc_pkg::OFS_SLOPE_SECOND_LO: next_s.slopeSecondLow     = regWrData;
        clsc_pkg::OFS_DECEL_CAP_CTRL:  next_s.decelCapCtrl       = regWrData;
        default: begin
        end
      endcase
    end
    if (regRdEn) begin
      next_s.rdData = read_mux(s, regAddr);
    end

    // Direction holds while the command is steady
    if (speedCommand < s.lastCmd) begin
      dirNow = 1'b1;
    end else if (speedCommand > s.lastCmd) begin
      dirNow = 1'b0;
    end
    next_s.dirDown = dirNow;
    next_s.lastCmd = speedCommand;

    next_s.tickCnt    = tick ? 32'h0000_0000 : s.tickCnt + 32'h0000_0001;
    next_s.bypass     = 1'b0;
    next_s.bypassDuty = 10'h000;
    next_s.loopClosed = ~loopSelect;

    if (loopSelect) begin
      next_s.zone = clsc_pkg::ZONE_OPEN;
    end else if (cmdDuty <= launchDuty) begin
      next_s.zone = clsc_pkg::ZONE_LOW;
      lowFull = zeroCmdFullSpeed && (isZero || (keepSpinningLow && inHalt));
      if (lowFull) begin
        if (fullDutyBypass) begin
          next_s.zone       = clsc_pkg::ZONE_BYPASS;
          next_s.bypass     = 1'b1;
          next_s.bypassDuty = clsc_pkg::FULL_DUTY;
        end else begin
          rawSpeed = maxSpeed;
        end
      end else if (keepSpinningLow) begin
        rawSpeed = 20'(launchSpeed);
      end else if (isZero || inHalt) begin
        rawSpeed = 20'h00000;
      end else begin
        rawSpeed = dirNow ? 20'(launchSpeed) : 20'h00000;
      end
    end else if (fullDutyBypass && (cmdDuty >= topDuty)) begin
      next_s.zone       = clsc_pkg::ZONE_BYPASS;
      next_s.bypass     = 1'b1;
      next_s.bypassDuty = cmdDuty;
    end else begin
      next_s.zone = clsc_pkg::ZONE_CURVE;
      rawSpeed    = curveSpeed;
    end

    // Target is held while duty bypasses the loop
    if (loopSelect) begin
      next_s.target = 20'h00000;
    end else if (!next_s.bypass) begin
      floorSpeed = (s.target > capStep) ? (s.target - capStep) : 20'h00000;
      if (rawSpeed >= s.target) begin
        next_s.target = rawSpeed;
      end else if (capStep == 20'h00000) begin
        next_s.target = rawSpeed;
      end else if (tick) begin
        next_s.target = (rawSpeed > floorSpeed) ? rawSpeed : floorSpeed;
      end
    end
  end

  // ********************************************************
  // Registers
  // ********************************************************
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s <= STATE_RST;
    end else begin
      s <= next_s;
    end
  end

  // ********************************************************
  // Outputs
  // ********************************************************
  assign regRdData    = s.rdData;
  assign targetSpeed  = s.target;
  assign bypassActive = s.bypass;
  assign bypassDuty   = s.bypassDuty;
  assign loopClosed   = s.loopClosed;
  assign curveZone    = s.zone;

endmodule

// ---- verification/clsc_speed_map_properties.sv ----
// Port-level properties of the closed-loop speed curve mapper
`timescale 1ns/1ps
module clsc_speed_map_properties (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        arst_n,
  // Register port
  input wire logic [4:0]  regAddr,
  input wire logic [7:0]  regWrData,
  input wire logic        regWrEn,
  input wire logic        regRdEn,
  input wire logic [7:0]  regRdData,
  // Command and results
  input wire logic [8:0]  speedCommand,
  input wire logic [19:0] targetSpeed,
  input wire logic        bypassActive,
  input wire logic [9:0]  bypassDuty,
  input wire logic        loopClosed,
  input wire logic [1:0]  curveZone
);
  logic mapped;
  assign mapped = ((regAddr >= 5'h02) && (regAddr <= 5'h0B)) || (regAddr == 5'h12);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // ********************************************************
  // Assertions
  // ********************************************************
  a_rd_unmapped: assert property (regRdEn && !mapped |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_rd_data_hold: assert property (!regRdEn |=> $stable(regRdData))
    else $error("read data moved without a read");
  a_open_zone: assert property (!loopClosed |-> curveZone == 2'h0)
    else $error("open loop zone wrong");
  a_loop_follow: assert property (regWrEn && regAddr == clsc_pkg::OFS_SLOPE_SECOND_LO
    |-> ##2 loopClosed == !$past(regWrData[0], 2))
    else $error("loop select not followed");
  a_duty_idle_zero: assert property (!bypassActive |-> bypassDuty == 10'h000)
    else $error("duty out while not bypassing");
  a_zone_bypass: assert property (curveZone == 2'h3 |-> bypassActive)
    else $error("bypass zone without bypass");
  a_bypass_duty: assert property (bypassActive && bypassDuty != clsc_pkg::FULL_DUTY
    |-> bypassDuty == {1'b0, $past(speedCommand)})
    else $error("bypass duty differs from command");
  a_bypass_holds: assert property (bypassActive ##1 bypassActive |-> $stable(targetSpeed))
    else $error("target moved during bypass");
  a_zero_cmd_low: assert property (loopClosed && $past(speedCommand) == 9'h000
    |-> (curveZone == 2'h1) || (curveZone == 2'h3))
    else $error("zero command outside low zone");
  // Main scenarios reached
  c_bypass: cover property (bypassActive && bypassDuty != clsc_pkg::FULL_DUTY);
  c_open: cover property (!loopClosed);
  c_descent: cover property (curveZone == 2'h2 && targetSpeed < $past(targetSpeed));
endmodule

// ---- verification/clsc_speed_map_tb_top.sv ----
// Self-checking bench for the closed-loop speed curve mapper
`timescale 1ns/1ps
module clsc_speed_map_tb_top;
  logic        ref_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [4:0]  regAddr = 5'h00;
  logic [7:0]  regWrData = 8'h00;
  logic        regWrEn = 1'b0;
  logic        regRdEn = 1'b0;
  logic [7:0]  regRdData;
  logic [8:0]  speedCommand = 9'h000;
  logic [19:0] targetSpeed;
  logic        bypassActive;
  logic [9:0]  bypassDuty;
  logic        loopClosed;
  logic [1:0]  curveZone;
  logic [7:0]  r [0:31];
  int          n_fail = 0;
  int          n_tests = 0;
  int          prevC, eT, eBd, eZ, lo, hl, tp;
  logic        fall, eBy, full;
  always #10 ref_clk = ~ref_clk;
  clsc_speed_map #(.DECEL_PERIOD_CYCLES(8)) uut (
    .ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .speedCommand(speedCommand), .targetSpeed(targetSpeed), .bypassActive(bypassActive),
    .bypassDuty(bypassDuty), .loopClosed(loopClosed), .curveZone(curveZone));
  // ********************************************************
  // Tasks and expectation model
  // ********************************************************
  task automatic check(input string nm, input logic [19:0] e, input logic [19:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic conclude();
    if ((n_fail == 0) && (n_tests > 0)) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  function automatic logic ismap(input logic [4:0] a);
    return ((a >= 5'h02) && (a <= 5'h0B)) || (a == 5'h12);
  endfunction
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #1;
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(posedge ref_clk);
    #1;
    regWrEn = 1'b0;
    if (ismap(a)) r[a] = d;
  endtask
  task automatic rdchk(input logic [4:0] a);
    @(posedge ref_clk);
    #1;
    regAddr = a;
    regRdEn = 1'b1;
    @(posedge ref_clk);
    #1;
    regRdEn = 1'b0;
    @(posedge ref_clk);
    #1;
    check("regRdData", ismap(a) ? 20'(r[a]) : 20'h0, 20'(regRdData));
  endtask
  function automatic int curve(input int d);
    int kn, v;
    kn = 2 * r[4];
    v = {r[6], r[7][7:4]} + (({r[8], r[9][7:2]} * ((kn != 0 && d > kn) ? kn : d) -
        {r[8], r[9][7:2]} * r[3]) >> 6);
    if (kn != 0 && d > kn) v = v + (({r[10], r[11][7:2]} * (d - kn)) >> 6);
    return v;
  endfunction
  task automatic model(input int c);
    int old;
    old = eT;
    hl = 2 * r[2][6:0];
    lo = r[3];
    tp = r[5] + 257;
    eBy = 1'b0;
    eBd = 0;
    if (c < prevC) fall = 1'b1;
    else if (c > prevC) fall = 1'b0;
    prevC = c;
    full = !r[11][0] && (c <= lo) && r[9][0] && ((c == 0) || (r[2][7] && (c <= hl)));
    if (r[11][0]) begin
      eZ = 0;
      eT = 0;
    end else if (c <= lo) begin
      eZ = 1;
      eT = (r[2][7] || ((c > hl) && fall)) ? {r[6], r[7][7:4]} : 0;
    end else if ((c >= tp) && r[9][1]) begin
      eZ = 3;
      eBy = 1'b1;
      eBd = c;
    end else begin
      eZ = 2;
      eT = curve((c > tp) ? tp : c);
    end
    if (full && r[9][1]) begin
      eBy = 1'b1;
      eBd = 'h200;
      eZ = 3;
      eT = old;
    end else if (full) eT = curve(tp);
  endtask
  task automatic drive(input int c);
    speedCommand = 9'(c);
    model(c);
  endtask
  task automatic outchk();
    check("targetSpeed", 20'(eT), targetSpeed);
    check("bypassActive", 20'(eBy), 20'(bypassActive));
    check("bypassDuty", 20'(eBd), 20'(bypassDuty));
    check("loopClosed", 20'(!r[11][0]), 20'(loopClosed));
    check("curveZone", 20'(eZ), 20'(curveZone));
  endtask
  task automatic apply(input int c);
    drive(c);
    repeat (3) @(posedge ref_clk);
    #1;
    outchk();
  endtask
  // Knee kept between launch and top, unused knee left at zero
  task automatic randcfg();
    int kspan;
    for (int a = 2; a <= 11; a++) r[a] = 8'($urandom);
    r[11][0] = 1'b0;
    kspan = (r[5] + 256) / 2 - r[3] / 2;
    r[4] = ($urandom % 2) ? 8'(r[3] / 2 + 1 + $urandom % kspan) : 8'h00;
    for (int a = 2; a <= 11; a++) wr(5'(a), r[a]);
    wr(5'h12, 8'h00);
    apply(r[3] + 1);
  endtask
  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    int cmd, prv, lim;
    int corner [8];
    int caps [7];
    void'($urandom(83837));
    for (int a = 0; a < 32; a++) r[a] = 8'h00;
    prevC = 0;
    fall = 1'b0;
    eT = 0;
    repeat (8) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    apply(0);
    for (int a = 0; a < 20; a++) rdchk(5'(a));
    wr(5'h0B, 8'h01);
    apply(300);
    for (int a = 0; a < 20; a++) wr(5'(a), 8'($urandom));
    for (int a = 0; a < 20; a++) rdchk(5'(a));
    for (int i = 0; i < 240; i++) begin
      if (i % 20 == 0) randcfg();
      corner = '{0, hl, hl + 1, lo, lo + 1, tp - 1, tp, 511};
      cmd = ($urandom % 3 == 0) ? $urandom % 512 : corner[$urandom % 8];
      apply((cmd > 511) ? 511 : cmd);
    end
    caps = '{512, 2200, 3800, 5400, 7000, 8600, 10240};
    for (int a = 2; a <= 11; a++) wr(5'(a), 8'h00);
    wr(5'h03, 8'h10);
    wr(5'h05, 8'hFF);
    wr(5'h08, 8'hFF);
    wr(5'h09, 8'hFC);
    for (int k = 1; k < 8; k++) begin
      wr(5'h12, 8'(k << 5));
      apply(511);
      prv = eT;
      // Capped fall spans many periods, so outputs are checked once it settles
      drive(17);
      lim = 0;
      while (targetSpeed !== 20'(eT)) begin
        if (targetSpeed !== 20'(prv)) begin
          check("capStep", 20'((prv - caps[k-1] > eT) ? prv - caps[k-1] : eT), targetSpeed);
          prv = targetSpeed;
        end
        @(posedge ref_clk);
        #1;
        lim++;
        if (lim > 4000) begin
          n_fail++;
          break;
        end
      end
      outchk();
    end
    conclude();
  end
endmodule

bind clsc_speed_map clsc_speed_map_properties u_props (
  .ref_clk(ref_clk), .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData),
  .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
  .speedCommand(speedCommand), .targetSpeed(targetSpeed), .bypassActive(bypassActive),
  .bypassDuty(bypassDuty), .loopClosed(loopClosed), .curveZone(curveZone));
